// [core/switch_matrix_control.v]
// Decided for this implementation: the Wishbone interface to the registers.
`include "switch_matrix_defs.vh"

// Overview of operation
// RULE_01: group bit 16 picks coded group fields (0) or individual registers (1).
// RULE_02: software writes individual registers first, then sets the source bit.
// RULE_03: four read-only status registers report the true state of every switch.
// RULE_04: in coded mode group bits 18 and 17 drive the two auxiliary tia switches directly.
// RULE_05: tia code: 0 open, 1-7 one switch, 8 cal, 9 all, 10-15 open.
// RULE_06: negative code: ldo a, 1-7, reserved, 9, cal, ldo b, all open.
// RULE_07: positive code: ldo a, cal, 2-9, 11, ldo b, reserved and 15 open.
// RULE_08: output code: 0 open, 1 cal, 2-4 one switch, 10-15 open.
// RULE_09: output codes 5 to 8 close switches 5 to 8; code 9 opens all.
// RULE_10: group register resets to 0x0000ffff, so every coded field starts at 1111.
// RULE_11: individual registers are read-write; status registers read-only; both reset zero.
// RULE_12: in hibernate software should close all four ldo-tie switches.
// RULE_13: every switch is open from reset until software configures the matrix.
// RULE_14: each defined individual register bit closes its own switch when one.
// RULE_15: reserved codes open the whole group; reserved bits read back zero.
module switch_matrix_control #(
   parameter ADR_W = 16
) (
   input wire i_ref_clk,
   input wire i_rst,
   input wire i_wb_cyc,
   input wire i_wb_stb,
   input wire i_wb_we,
   input wire [ADR_W-1:0] i_wb_adr,
   input wire [3:0] i_wb_sel,
   input wire [31:0] i_wb_dat,
   output wire [31:0] o_wb_dat,
   output wire o_wb_ack,
   output wire [`SWM_AMP_W-1:0] o_amp_sw,
   output wire [`SWM_POS_W-1:0] o_pos_sw,
   output wire [`SWM_NEG_W-1:0] o_neg_sw,
   output wire [`SWM_TIA_W-1:0] o_tia_sw
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   reg [31:0] group_cfg_r;
   reg [31:0] amp_ind_r;
   reg [31:0] neg_ind_r;
   reg [31:0] pos_ind_r;
   reg [31:0] tia_ind_r;
   reg [`SWM_AMP_W-1:0] amp_sw_r;
   reg [`SWM_POS_W-1:0] pos_sw_r;
   reg [`SWM_NEG_W-1:0] neg_sw_r;
   reg [`SWM_TIA_W-1:0] tia_sw_r;
   reg [`SWM_AMP_W-1:0] amp_sw_nxt;
   reg [`SWM_POS_W-1:0] pos_sw_nxt;
   reg [`SWM_NEG_W-1:0] neg_sw_nxt;
   reg [`SWM_TIA_W-1:0] tia_sw_nxt;
   reg ack_r;
   reg [31:0] rd_dat_r;
   reg [31:0] rd_dat_nxt;

   wire [`SWM_AMP_W-1:0] amp_dec;
   wire [`SWM_POS_W-1:0] pos_dec;
   wire [`SWM_NEG_W-1:0] neg_dec;
   wire [`SWM_TIA_W-1:0] tia_dec;
   wire req;
   wire wr;
   wire src_individual;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // byte-lane write merge; bits outside the mask stay zero
   function [31:0] wmerge;
      input [31:0] old_val;
      input [31:0] new_val;
      input [3:0] sel;
      input [31:0] mask;
      integer k;
      reg [31:0] tmp;
      begin
         tmp = old_val;
         for (k = 0; k < 4; k = k + 1) begin
            if (sel[k]) begin
               tmp[8*k +: 8] = new_val[8*k +: 8];
            end
         end
         wmerge = tmp & mask;
      end
   endfunction

   function hit;
      input [ADR_W-1:0] adr;
      input [15:0] offset;
      begin
         hit = ({{(32-ADR_W){1'b0}}, adr} == {16'h0000, offset});
      end
   endfunction

   // ------------------------------------------------------------
   // wishbone slave
   // ------------------------------------------------------------
   // one new request per ack; masking the request in the ack cycle
   // keeps a held request from being taken twice
   assign req = i_wb_cyc & i_wb_stb & ~ack_r;
   assign wr = req & i_wb_we;
   assign o_wb_ack = ack_r;
   assign o_wb_dat = rd_dat_r;

   always @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req;
      end
   end

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   always @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         group_cfg_r <= `SWM_RST_GROUP_CFG;                  // RULE_10
         amp_ind_r <= `SWM_RST_IND;                          // RULE_11
         neg_ind_r <= `SWM_RST_IND;                          // RULE_11
         pos_ind_r <= `SWM_RST_IND;                          // RULE_11
         tia_ind_r <= `SWM_RST_IND;                          // RULE_11
      end else if (wr) begin
         if (hit(i_wb_adr, `SWM_ADR_GROUP_CFG)) begin
            group_cfg_r <= wmerge(group_cfg_r, i_wb_dat, i_wb_sel, `SWM_GROUP_MASK); // RULE_15
         end
         if (hit(i_wb_adr, `SWM_ADR_AMP_IND)) begin
            amp_ind_r <= wmerge(amp_ind_r, i_wb_dat, i_wb_sel, `SWM_AMP_MASK); // RULE_11 RULE_15
         end
         if (hit(i_wb_adr, `SWM_ADR_NEG_IND)) begin
            neg_ind_r <= wmerge(neg_ind_r, i_wb_dat, i_wb_sel, `SWM_NEG_MASK); // RULE_11 RULE_15
         end
         if (hit(i_wb_adr, `SWM_ADR_POS_IND)) begin
            pos_ind_r <= wmerge(pos_ind_r, i_wb_dat, i_wb_sel, `SWM_POS_MASK); // RULE_11 RULE_15
         end
         if (hit(i_wb_adr, `SWM_ADR_TIA_IND)) begin
            tia_ind_r <= wmerge(tia_ind_r, i_wb_dat, i_wb_sel, `SWM_TIA_MASK); // RULE_11 RULE_15
         end
      end
   end

   // ------------------------------------------------------------
   // group decode
   // ------------------------------------------------------------
   switch_decode u_decode (
      .i_amp_output_mux_code(group_cfg_r[`SWM_AMP_CODE_LSB +: 4]),
      .i_pos_node_mux_code(group_cfg_r[`SWM_POS_CODE_LSB +: 4]),
      .i_neg_node_mux_code(group_cfg_r[`SWM_NEG_CODE_LSB +: 4]),
      .i_tia_mux_code(group_cfg_r[`SWM_TIA_CODE_LSB +: 4]),
      .o_amp_sw(amp_dec),
      .o_pos_sw(pos_dec),
      .o_neg_sw(neg_dec),
      .o_tia_sw(tia_dec)
   );

   // ------------------------------------------------------------
   // switch drive select
   // ------------------------------------------------------------
   // individual values only reach the switches through this bit,
   // so software must load them before setting it
   assign src_individual = group_cfg_r[`SWM_SRC_SEL_BIT];    // RULE_01 RULE_02

   always @* begin
      if (src_individual) begin
         amp_sw_nxt = amp_ind_r[`SWM_AMP_W-1:0];             // RULE_01 RULE_14
         pos_sw_nxt = pos_ind_r[`SWM_POS_W-1:0];             // RULE_01 RULE_14
         neg_sw_nxt = neg_ind_r[`SWM_NEG_W-1:0];             // RULE_01 RULE_14
         tia_sw_nxt = tia_ind_r[`SWM_TIA_W-1:0];             // RULE_01 RULE_14
      end else begin
         amp_sw_nxt = amp_dec;                               // RULE_01
         pos_sw_nxt = pos_dec;                               // RULE_01
         neg_sw_nxt = neg_dec;                               // RULE_01
         tia_sw_nxt = tia_dec;
         // auxiliary pair follows its own group bits only
         tia_sw_nxt[`SWM_TIA_AUX_A_SW] = group_cfg_r[`SWM_TIA_AUX_A_BIT]; // RULE_04
         tia_sw_nxt[`SWM_TIA_AUX_B_SW] = group_cfg_r[`SWM_TIA_AUX_B_BIT]; // RULE_04
      end
   end

   // registered drive keeps decode glitches off the analog switches
   always @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         amp_sw_r <= {`SWM_AMP_W{1'b0}};                     // RULE_13
         pos_sw_r <= {`SWM_POS_W{1'b0}};                     // RULE_13
         neg_sw_r <= {`SWM_NEG_W{1'b0}};                     // RULE_13
         tia_sw_r <= {`SWM_TIA_W{1'b0}};                     // RULE_13
      end else begin
         amp_sw_r <= amp_sw_nxt;
         pos_sw_r <= pos_sw_nxt;
         neg_sw_r <= neg_sw_nxt;
         tia_sw_r <= tia_sw_nxt;
      end
   end

   assign o_amp_sw = amp_sw_r;
   assign o_pos_sw = pos_sw_r;
   assign o_neg_sw = neg_sw_r;
   assign o_tia_sw = tia_sw_r;

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   // status words are the switch flops themselves, valid in either mode
   always @* begin
      rd_dat_nxt = 32'h0000_0000;
      if (hit(i_wb_adr, `SWM_ADR_GROUP_CFG)) begin
         rd_dat_nxt = group_cfg_r;
      end else if (hit(i_wb_adr, `SWM_ADR_AMP_IND)) begin
         rd_dat_nxt = amp_ind_r;
      end else if (hit(i_wb_adr, `SWM_ADR_NEG_IND)) begin
         rd_dat_nxt = neg_ind_r;
      end else if (hit(i_wb_adr, `SWM_ADR_POS_IND)) begin
         rd_dat_nxt = pos_ind_r;
      end else if (hit(i_wb_adr, `SWM_ADR_TIA_IND)) begin
         rd_dat_nxt = tia_ind_r;
      end else if (hit(i_wb_adr, `SWM_ADR_AMP_STA)) begin
         rd_dat_nxt[`SWM_AMP_W-1:0] = amp_sw_r;              // RULE_03
      end else if (hit(i_wb_adr, `SWM_ADR_POS_STA)) begin
         rd_dat_nxt[`SWM_POS_W-1:0] = pos_sw_r;              // RULE_03
      end else if (hit(i_wb_adr, `SWM_ADR_NEG_STA)) begin
         rd_dat_nxt[`SWM_NEG_W-1:0] = neg_sw_r;              // RULE_03
      end else if (hit(i_wb_adr, `SWM_ADR_TIA_STA)) begin
         rd_dat_nxt[`SWM_TIA_W-1:0] = tia_sw_r;              // RULE_03
      end
   end

   // read data is loaded on the taking edge of a read and held until the next read request
   always @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         rd_dat_r <= 32'h0000_0000;
      end else if (req & ~i_wb_we) begin
         rd_dat_r <= rd_dat_nxt;                             // RULE_11 RULE_15
      end
   end

endmodule

// [core/switch_matrix_defs.vh]
`ifndef SWITCH_MATRIX_DEFS_VH
`define SWITCH_MATRIX_DEFS_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define SWM_ADR_GROUP_CFG 16'h200C
`define SWM_ADR_AMP_IND 16'h2150
`define SWM_ADR_NEG_IND 16'h2154
`define SWM_ADR_POS_IND 16'h2158
`define SWM_ADR_TIA_IND 16'h215C
`define SWM_ADR_AMP_STA 16'h21B0
`define SWM_ADR_POS_STA 16'h21B4
`define SWM_ADR_NEG_STA 16'h21B8
`define SWM_ADR_TIA_STA 16'h21BC

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define SWM_RST_GROUP_CFG 32'h0000_FFFF
`define SWM_RST_IND 32'h0000_0000

// ------------------------------------------------------------
// group register fields
// ------------------------------------------------------------
`define SWM_AMP_CODE_LSB 0
`define SWM_POS_CODE_LSB 4
`define SWM_NEG_CODE_LSB 8
`define SWM_TIA_CODE_LSB 12
`define SWM_SRC_SEL_BIT 16
`define SWM_TIA_AUX_A_BIT 17
`define SWM_TIA_AUX_B_BIT 18
`define SWM_GROUP_MASK 32'h0007_FFFF

// ------------------------------------------------------------
// switch vector widths and bit positions
// ------------------------------------------------------------
`define SWM_AMP_W 8
`define SWM_NEG_W 12
`define SWM_POS_W 13
`define SWM_TIA_W 12
`define SWM_AMP_MASK 32'h0000_00FF
`define SWM_NEG_MASK 32'h0000_0FFF
`define SWM_POS_MASK 32'h0000_1FFF
`define SWM_TIA_MASK 32'h0000_0B7F
`define SWM_NEG_N9_BIT 8
`define SWM_NEG_CAL_BIT 9
`define SWM_NEG_LDO_A_BIT 10
`define SWM_NEG_LDO_B_BIT 11
`define SWM_POS_CAL_BIT 0
`define SWM_POS_P11_BIT 10
`define SWM_POS_LDO_A_BIT 11
`define SWM_POS_LDO_B_BIT 12
`define SWM_TIA_AUX_A_SW 8
`define SWM_TIA_AUX_B_SW 9
`define SWM_TIA_CAL_BIT 11
`define SWM_TIA_ALL_MUX 12'h087F

`endif

// [core/switch_decode.v]
`include "switch_matrix_defs.vh"

// decodes the four coded group fields into one-bit-per-switch vectors
module switch_decode (
   input wire [3:0] i_amp_output_mux_code,
   input wire [3:0] i_pos_node_mux_code,
   input wire [3:0] i_neg_node_mux_code,
   input wire [3:0] i_tia_mux_code,
   output reg [`SWM_AMP_W-1:0] o_amp_sw,
   output reg [`SWM_POS_W-1:0] o_pos_sw,
   output reg [`SWM_NEG_W-1:0] o_neg_sw,
   output reg [`SWM_TIA_W-1:0] o_tia_sw
);

   // ------------------------------------------------------------
   // numbered switch n sits at bit n-1 in every group
   // ------------------------------------------------------------
   function [15:0] numbered;
      input [3:0] code;
      begin
         numbered = 16'h0001 << (code - 4'h1);
      end
   endfunction

   // one-hot of each field, sliced to the group width where used
   wire [15:0] amp_num = numbered(i_amp_output_mux_code);
   wire [15:0] pos_num = numbered(i_pos_node_mux_code);
   wire [15:0] neg_num = numbered(i_neg_node_mux_code);
   wire [15:0] tia_num = numbered(i_tia_mux_code);

   always @* begin
      o_amp_sw = {`SWM_AMP_W{1'b0}};
      case (i_amp_output_mux_code)
         4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8: begin
            o_amp_sw = amp_num[`SWM_AMP_W-1:0];               // RULE_08 RULE_09
         end
         default: begin
            o_amp_sw = {`SWM_AMP_W{1'b0}};                    // RULE_08 RULE_09
         end
      endcase
   end

   always @* begin
      o_pos_sw = {`SWM_POS_W{1'b0}};
      case (i_pos_node_mux_code)
         4'h0: o_pos_sw[`SWM_POS_LDO_A_BIT] = 1'b1;           // RULE_07
         4'h1: o_pos_sw[`SWM_POS_CAL_BIT] = 1'b1;             // RULE_07
         4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9: begin
            o_pos_sw = pos_num[`SWM_POS_W-1:0];               // RULE_07
         end
         4'hB: o_pos_sw[`SWM_POS_P11_BIT] = 1'b1;             // RULE_07
         4'hD, 4'hE: o_pos_sw[`SWM_POS_LDO_B_BIT] = 1'b1;     // RULE_07
         default: o_pos_sw = {`SWM_POS_W{1'b0}};              // RULE_15
      endcase
   end

   always @* begin
      o_neg_sw = {`SWM_NEG_W{1'b0}};
      case (i_neg_node_mux_code)
         4'h0: o_neg_sw[`SWM_NEG_LDO_A_BIT] = 1'b1;           // RULE_06
         4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: begin
            o_neg_sw = neg_num[`SWM_NEG_W-1:0];               // RULE_06
         end
         4'h9: o_neg_sw[`SWM_NEG_N9_BIT] = 1'b1;              // RULE_06
         4'hA: o_neg_sw[`SWM_NEG_CAL_BIT] = 1'b1;             // RULE_06
         4'hB, 4'hC, 4'hD, 4'hE: o_neg_sw[`SWM_NEG_LDO_B_BIT] = 1'b1; // RULE_06
         default: o_neg_sw = {`SWM_NEG_W{1'b0}};              // RULE_15
      endcase
   end

   // the auxiliary pair never comes from this field
   always @* begin
      o_tia_sw = {`SWM_TIA_W{1'b0}};
      case (i_tia_mux_code)
         4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: begin
            o_tia_sw = tia_num[`SWM_TIA_W-1:0];               // RULE_05
         end
         4'h8: o_tia_sw[`SWM_TIA_CAL_BIT] = 1'b1;             // RULE_05
         4'h9: o_tia_sw = `SWM_TIA_ALL_MUX;                   // RULE_05
         default: o_tia_sw = {`SWM_TIA_W{1'b0}};              // RULE_05 RULE_04
      endcase
   end

endmodule

// [testbench/switch_matrix_control_assertions.sv]
`include "switch_matrix_defs.vh"

module switch_matrix_control_chk #(
   parameter ADR_W = 16
) (
   input wire i_ref_clk,
   input wire i_rst,
   input wire i_wb_cyc,
   input wire i_wb_stb,
   input wire i_wb_we,
   input wire [ADR_W-1:0] i_wb_adr,
   input wire [3:0] i_wb_sel,
   input wire [31:0] i_wb_dat,
   input wire [31:0] o_wb_dat,
   input wire o_wb_ack,
   input wire [`SWM_AMP_W-1:0] o_amp_sw,
   input wire [`SWM_POS_W-1:0] o_pos_sw,
   input wire [`SWM_NEG_W-1:0] o_neg_sw,
   input wire [`SWM_TIA_W-1:0] o_tia_sw
);
   wire rq = i_wb_cyc && i_wb_stb && !o_wb_ack;
   wire wr = rq && i_wb_we;
   wire rd = rq && !i_wb_we;
   // -----------------------------------------
   // full group write in coded mode
   // -----------------------------------------
   wire gw = wr && i_wb_adr == `SWM_ADR_GROUP_CFG && i_wb_sel[2:0] == 3'b111 && !i_wb_dat[16];
   wire [44:0] sw = {o_amp_sw, o_pos_sw, o_neg_sw, o_tia_sw};
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   property p_ack_once; rq |=> o_wb_ack ##1 !o_wb_ack; endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack not a single pulse");
   property p_rst_open; $fell(i_rst) |-> sw == 45'h0 && !o_wb_ack; endproperty
   a_rst_open: assert property (p_rst_open) else $error("switch closed after reset");
   // switches may only move as a consequence of a write
   property p_sw_cause; $changed(sw) |-> $past(wr, 1) || $past(wr, 2); endproperty
   a_sw_cause: assert property (p_sw_cause) else $error("switch moved without write");
   property p_aux; gw |-> ##2 (o_tia_sw[9:8] == $past(i_wb_dat[18:17], 2)); endproperty
   a_aux: assert property (p_aux) else $error("aux tia switch wrong");
   property p_onehot; gw |-> ##2 ($onehot0(o_amp_sw) && $onehot0(o_pos_sw) && $onehot0(o_neg_sw)); endproperty
   a_onehot: assert property (p_onehot) else $error("more than one switch closed");
   property p_tia_all; gw && i_wb_dat[15:12] == 4'h9 |-> ##2 (o_tia_sw[7:0] == 8'h7F && o_tia_sw[11]); endproperty
   a_tia_all: assert property (p_tia_all) else $error("tia code 9 wrong");
   property p_neg_rsvd; gw && i_wb_dat[11:8] == 4'h8 |-> ##2 o_neg_sw == 12'h000; endproperty
   a_neg_rsvd: assert property (p_neg_rsvd) else $error("reserved code closed switch");
   property p_sta; rd && i_wb_adr == `SWM_ADR_AMP_STA |=> o_wb_dat == {24'h00_0000, $past(o_amp_sw)}; endproperty
   a_sta: assert property (p_sta) else $error("status read wrong");
   property p_rd_hold; !rd |=> $stable(o_wb_dat); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_ind_rsvd; rd && i_wb_adr == `SWM_ADR_TIA_IND |=> (o_wb_dat & ~`SWM_TIA_MASK) == 32'h0000_0000; endproperty
   a_ind_rsvd: assert property (p_ind_rsvd) else $error("reserved bits set");
endmodule

bind switch_matrix_control switch_matrix_control_chk #(.ADR_W(ADR_W)) chk_i (.i_ref_clk(i_ref_clk),
   .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
   .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_amp_sw(o_amp_sw),
   .o_pos_sw(o_pos_sw), .o_neg_sw(o_neg_sw), .o_tia_sw(o_tia_sw));

// [testbench/testbench.sv]
`include "switch_matrix_defs.vh"

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_ref_clk = 0, i_rst = 1, cyc = 0, stb = 0, we = 0;
   logic [15:0] adr = 16'h0000, lfsr = 16'h0008;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0000_0000, grp, r, d;
   logic [31:0] ind [4];
   wire [31:0] o_wb_dat;
   wire o_wb_ack;
   wire [`SWM_AMP_W-1:0] amp;
   wire [`SWM_POS_W-1:0] pos;
   wire [`SWM_NEG_W-1:0] neg;
   wire [`SWM_TIA_W-1:0] tia;
   wire [31:0] sw [4];
   int failures = 0, compares = 0, cycles = 0;
   localparam logic [15:0] ADRS [10] = '{`SWM_ADR_GROUP_CFG, `SWM_ADR_AMP_IND, `SWM_ADR_NEG_IND, `SWM_ADR_POS_IND,
      `SWM_ADR_TIA_IND, `SWM_ADR_AMP_STA, `SWM_ADR_POS_STA, `SWM_ADR_NEG_STA, `SWM_ADR_TIA_STA, 16'h2160};
   localparam logic [31:0] MSK [4] = '{`SWM_AMP_MASK, `SWM_POS_MASK, `SWM_NEG_MASK, `SWM_TIA_MASK};
   assign sw[0] = 32'(amp);
   assign sw[1] = 32'(pos);
   assign sw[2] = 32'(neg);
   assign sw[3] = 32'(tia);
   always #2.5 i_ref_clk = ~i_ref_clk;
   switch_matrix_control switch_matrix_control_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(o_wb_dat),
      .o_wb_ack(o_wb_ack), .o_amp_sw(amp), .o_pos_sw(pos), .o_neg_sw(neg), .o_tia_sw(tia));
   // ----------------------------------------------
   // reference model
   // ----------------------------------------------
   task automatic rnd(output logic [31:0] v);
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      v[31:16] = lfsr;
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      v[15:0] = lfsr;
   endtask
   function automatic int ix(logic [15:0] a);
      case (a)
         `SWM_ADR_AMP_IND: return 0;
         `SWM_ADR_POS_IND: return 1;
         `SWM_ADR_NEG_IND: return 2;
         `SWM_ADR_TIA_IND: return 3;
         default: return -1;
      endcase
   endfunction
   // node order amp, pos, neg, tia matches both field order and status offsets
   function automatic logic [31:0] exp_sw(int k);
      int c;
      logic [31:0] e;
      c = (grp >> (4 * k)) & 15;
      e = 0;
      if (grp[16]) return ind[k];
      case (k)
         0: if (c >= 1 && c <= 8) e = 1 << (c - 1);
         1: if (c >= 1 && c <= 9) e = 1 << (c - 1); else if (c == 11) e = 1 << 10;
            else if (c == 0) e = 1 << 11; else if (c == 13 || c == 14) e = 1 << 12;
         2: if (c >= 1 && c <= 7) e = 1 << (c - 1); else if (c == 9) e = 1 << 8; else if (c == 10) e = 1 << 9;
            else if (c == 0) e = 1 << 10; else if (c >= 11 && c <= 14) e = 1 << 11;
         default: begin
            if (c >= 1 && c <= 7) e = 1 << (c - 1); else if (c == 8) e = 1 << 11; else if (c == 9) e = 32'h0000_087F;
            e[9:8] = grp[18:17];
         end
      endcase
      return e;
   endfunction
   function automatic logic [31:0] exp_rd(logic [15:0] a);
      if (a == `SWM_ADR_GROUP_CFG) return grp;
      if (ix(a) >= 0) return ind[ix(a)];
      if (a >= `SWM_ADR_AMP_STA && a <= `SWM_ADR_TIA_STA && a[1:0] == 2'b00) return exp_sw((a - `SWM_ADR_AMP_STA) >> 2);
      return 0;
   endfunction
   function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n, logic [3:0] s, logic [31:0] m);
      logic [31:0] b;
      b = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      return ((o & ~b) | (n & b)) & m;
   endfunction
   // ----------------------------------------------
   // checking and bus tasks
   // ----------------------------------------------
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_sw();
      @(negedge i_ref_clk);
      for (int k = 0; k < 4; k++) chk("switches", exp_sw(k), sw[k]);
   endtask
   task automatic test_done();
      if (failures == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] v, input logic [3:0] s);
      logic [31:0] e;
      int n;
      e = exp_rd(a);
      n = 0;
      @(posedge i_ref_clk);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      dat <= v;
      sel <= s;
      do begin
         @(posedge i_ref_clk);
         n++;
      end while (o_wb_ack !== 1'b1 && n < 50);
      if (n >= 50) begin
         failures++;
         $display("MISMATCH ack expected 1 seen %b", o_wb_ack);
         test_done();
      end
      cyc <= 0;
      stb <= 0;
      if (!w) chk("read data", e, o_wb_dat);
      else if (a == `SWM_ADR_GROUP_CFG) grp = merge(grp, v, s, `SWM_GROUP_MASK);
      else if (ix(a) >= 0) ind[ix(a)] = merge(ind[ix(a)], v, s, MSK[ix(a)]);
      chk_sw();
   endtask
   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles > 2000) begin
         failures++;
         $display("MISMATCH cycles expected below 2000 seen %0d", cycles);
         test_done();
      end
   end
   initial begin
      ind = '{default: 0};
      grp = `SWM_RST_GROUP_CFG;
      repeat (8) @(posedge i_ref_clk);
      i_rst <= 0;
      chk_sw();
      foreach (ADRS[i]) wb(0, ADRS[i], 0, 4'h0);
      for (int c = 0; c < 16; c++) begin
         rnd(r);
         wb(1, `SWM_ADR_GROUP_CFG, {13'h0000, r[18:17], 1'b0, {4{c[3:0]}}}, 4'hF);
         for (int k = 0; k < 4; k++) wb(0, ADRS[5 + k], 0, 4'h0);
      end
      wb(1, `SWM_ADR_POS_IND, 32'h0000_1800, 4'hF);
      wb(1, `SWM_ADR_NEG_IND, 32'h0000_0C00, 4'hF);
      wb(1, `SWM_ADR_GROUP_CFG, 32'h0001_FFFF, 4'hF);
      repeat (80) begin
         rnd(r);
         rnd(d);
         wb(r[0], ADRS[r[7:4] % 10], d, r[11:8]);
      end
      @(posedge i_ref_clk);
      i_rst <= 1;
      repeat (2) @(posedge i_ref_clk);
      i_rst <= 0;
      ind = '{default: 0};
      grp = `SWM_RST_GROUP_CFG;
      chk_sw();
      wb(0, `SWM_ADR_GROUP_CFG, 0, 4'h0);
      test_done();
   end
endmodule
